// ==== hw/cao_device.sv ====
// Clocked audio output: packet stream in, framed serial audio out
//
// Implementation choice: the byte register port or the channel and reset pins, by USE_REGS.
`timescale 1ns/100ps
`include "cao_defines.svh"
module cao_device #(
    parameter int FIFO_LOG2 = 5,
    parameter bit USE_REGS  = 1'b1
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    cao_stream_if.sink      stream,
    input  wire logic [1:0] reg_addr,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] channel0_in,
    input  wire logic [7:0] channel1_in,
    input  wire logic [7:0] fifo_reset_in,
    output logic            fifo_status,
    input  wire logic       serial_audio_clk,
    output logic            serial_audio_data,
    output logic            serial_audio_data_enable,
    output logic            serial_audio_word_select
);
    localparam int DEPTH = 2 ** FIFO_LOG2;

    logic [7:0]             first_channel_number;
    logic [7:0]             second_channel_number;
    logic                   overflow;
    cao_pkg::cao_entry_s    mem [DEPTH];
    logic [FIFO_LOG2:0]     wptr;
    logic [FIFO_LOG2:0]     rptr;
    logic [1:0]             lane_idx    [2];
    logic [1:0]             lane_kind   [2];
    cao_pkg::cao_word_t     lane_sample [2];
    logic [2:0]             lane_vuc    [2];
    logic                   lane_have   [2];
    logic                   sclk_s1;
    logic                   sclk_s2;
    logic                   sclk_s3;
    logic [4:0]             bit_cnt;
    logic [31:0]            shreg;
    logic [7:0]             frame_cnt;

    // ----------------------------------------------------------------
    // Subframe builder
    // ----------------------------------------------------------------
    function automatic logic [31:0] subframe(input cao_pkg::cao_entry_s e,
                                             input logic block_start);
        logic [3:0]  pre;
        logic [30:0] body;
        pre = e.lane ? `CAO_PREAMBLE_Y :
              (block_start ? `CAO_PREAMBLE_Z : `CAO_PREAMBLE_X);
        body = {e.status, e.user, e.validity, e.sample, pre};
        subframe = {^body[30:4], body};
    endfunction : subframe

    // ----------------------------------------------------------------
    // Control selection
    // ----------------------------------------------------------------
    wire [7:0] ch0 = USE_REGS ? first_channel_number  : channel0_in;
    wire [7:0] ch1 = USE_REGS ? second_channel_number : channel1_in;
    wire       reg_clear = reg_write && (reg_addr == `CAO_REG_BUFFER_CLEAR)
                           && reg_wdata[`CAO_CLEAR_BIT];
    wire       fifo_clear = USE_REGS ? reg_clear : fifo_reset_in[`CAO_CLEAR_BIT];
    wire [7:0] read_mux =
        (reg_addr == `CAO_REG_FIRST_CHANNEL)  ? first_channel_number  :
        (reg_addr == `CAO_REG_SECOND_CHANNEL) ? second_channel_number :
        (reg_addr == `CAO_REG_OVERFLOW_FLAG)  ? {7'h00, overflow}    :
                                                8'h00;

    assign fifo_status = overflow;
    assign stream.ready = !fifo_clear;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_channel_number  <= `CAO_RST_FIRST_CHANNEL;
            second_channel_number <= `CAO_RST_SECOND_CHANNEL;
            reg_rdata             <= 8'h00;
        end
        else
        begin
            if (reg_write && reg_addr == `CAO_REG_FIRST_CHANNEL)
                first_channel_number <= reg_wdata;
            if (reg_write && reg_addr == `CAO_REG_SECOND_CHANNEL)
                second_channel_number <= reg_wdata;
            if (reg_read)
                reg_rdata <= read_mux;
        end
    end

    // ----------------------------------------------------------------
    // Packet parser, one context per routed channel
    // ----------------------------------------------------------------
    wire       beat = stream.valid && stream.ready;
    wire       hit0 = beat && (stream.channel == ch0);
    wire       hit1 = beat && !hit0 && (stream.channel == ch1);
    wire [1:0] hit  = {hit1, hit0};
    wire [1:0] lane_push;

    for (genvar l = 0; l < 2; l++)
    begin : g_lane
        wire is_audio = (stream.data == `CAO_TYPE_AUDIO_DATA);
        wire is_ctrl  = (stream.data == `CAO_TYPE_AUDIO_CONTROL);
        wire at_idx   = hit[l] && !stream.sop;
        assign lane_push[l] = at_idx && stream.eop && lane_kind[l] == 2'h2
                              && lane_idx[l] == `CAO_BEAT_STATUS && lane_have[l];

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                lane_idx[l]    <= 2'h0;
                lane_kind[l]   <= 2'h0;
                lane_sample[l] <= 24'h00_0000;
                lane_vuc[l]    <= 3'h0;
                lane_have[l]   <= 1'b0;
            end
            else if (hit[l] && stream.sop)
            begin
                lane_idx[l]  <= `CAO_BEAT_SAMPLE;
                lane_kind[l] <= is_audio ? 2'h1 : (is_ctrl ? 2'h2 : 2'h0);
            end
            else if (at_idx)
            begin
                if (lane_idx[l] != 2'h3)
                    lane_idx[l] <= lane_idx[l] + 2'h1;
                if (lane_kind[l] == 2'h1 && lane_idx[l] == `CAO_BEAT_SAMPLE)
                begin
                    lane_sample[l] <= stream.data;
                    lane_have[l]   <= 1'b1;
                end
                if (lane_kind[l] == 2'h2)
                    lane_vuc[l][lane_idx[l] - 2'h1] <= stream.data[0];
                if (lane_push[l])
                    lane_have[l] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // FIFO
    // ----------------------------------------------------------------
    wire push_lane = lane_push[1];
    wire push      = |lane_push;
    wire empty     = (wptr == rptr);
    wire full      = (wptr[FIFO_LOG2] != rptr[FIFO_LOG2]) &&
                     (wptr[FIFO_LOG2-1:0] == rptr[FIFO_LOG2-1:0]);
    cao_pkg::cao_entry_s push_entry;
    cao_pkg::cao_entry_s head;
    assign push_entry = push_lane ?
        {1'b1, lane_vuc[1][0], lane_vuc[1][1], stream.data[0], lane_sample[1]} :
        {1'b0, lane_vuc[0][0], lane_vuc[0][1], stream.data[0], lane_sample[0]};
    assign head = mem[rptr[FIFO_LOG2-1:0]];

    wire tick = sclk_s2 && !sclk_s3;
    wire pop  = tick && (bit_cnt == 5'h00) && !empty;

    always_ff @(posedge pclk)
    begin
        if (push && !full)
            mem[wptr[FIFO_LOG2-1:0]] <= push_entry;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wptr     <= '0;
            rptr     <= '0;
            overflow <= 1'b0;
        end
        else
        begin
            if (push && full)
                overflow <= 1'b1;
            else if (fifo_clear)
                overflow <= 1'b0;
            if (fifo_clear)
            begin
                wptr <= '0;
                rptr <= '0;
            end
            else
            begin
                if (push && !full)
                    wptr <= wptr + {{FIFO_LOG2{1'b0}}, 1'b1};
                if (pop)
                    rptr <= rptr + {{FIFO_LOG2{1'b0}}, 1'b1};
            end
        end
    end

    // ----------------------------------------------------------------
    // Serialiser on sampled serial clock
    // ----------------------------------------------------------------
    wire [31:0] next_frame = subframe(head, frame_cnt == 8'h00);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
        end
        else
        begin
            sclk_s1 <= serial_audio_clk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_cnt                  <= 5'h00;
            shreg                    <= 32'h0000_0000;
            frame_cnt                <= 8'h00;
            serial_audio_data        <= 1'b0;
            serial_audio_data_enable <= 1'b0;
            serial_audio_word_select <= 1'b0;
        end
        else if (tick && bit_cnt == 5'h00)
        begin
            if (pop)
            begin
                serial_audio_data        <= next_frame[0];
                shreg                    <= {1'b0, next_frame[31:1]};
                serial_audio_data_enable <= 1'b1;
                serial_audio_word_select <= head.lane;
                bit_cnt                  <= 5'h01;
            end
            else
            begin
                serial_audio_data        <= 1'b0;
                serial_audio_data_enable <= 1'b0;
            end
        end
        else if (tick)
        begin
            serial_audio_data <= shreg[0];
            shreg             <= {1'b0, shreg[31:1]};
            bit_cnt           <= bit_cnt + 5'h01;
            if (bit_cnt == `CAO_LAST_BIT && serial_audio_word_select)
                frame_cnt <= (frame_cnt == `CAO_LAST_FRAME) ? 8'h00 :
                             frame_cnt + 8'h01;
        end
    end
endmodule : cao_device

// ==== hw/cao_defines.svh ====
// Shared constants for the clocked audio output block and its stream source
`ifndef CAO_DEFINES_SVH
`define CAO_DEFINES_SVH

// ----------------------------------------------------------------
// Device byte registers
// ----------------------------------------------------------------
`define CAO_REG_FIRST_CHANNEL   2'h0
`define CAO_REG_SECOND_CHANNEL  2'h1
`define CAO_REG_OVERFLOW_FLAG   2'h2
`define CAO_REG_BUFFER_CLEAR    2'h3
`define CAO_CLEAR_BIT           7
`define CAO_RST_FIRST_CHANNEL   8'h01
`define CAO_RST_SECOND_CHANNEL  8'h02

// ----------------------------------------------------------------
// Stream packets
// ----------------------------------------------------------------
`define CAO_TYPE_AUDIO_DATA     24'h00_000a
`define CAO_TYPE_AUDIO_CONTROL  24'h00_000e
`define CAO_BEAT_SAMPLE         2'h1
`define CAO_BEAT_VALIDITY       2'h1
`define CAO_BEAT_USER           2'h2
`define CAO_BEAT_STATUS         2'h3
`define CAO_BEATS_PER_LANE      4'h6
`define CAO_BEATS_PER_FRAME     4'hc

// ----------------------------------------------------------------
// Serial frame
// ----------------------------------------------------------------
`define CAO_PREAMBLE_X          4'h0
`define CAO_PREAMBLE_Y          4'h1
`define CAO_PREAMBLE_Z          4'h2
`define CAO_LAST_BIT            5'h1f
`define CAO_LAST_FRAME          8'hbf

// ----------------------------------------------------------------
// Source APB registers
// ----------------------------------------------------------------
`define CAO_APB_SAMPLE0         12'h000
`define CAO_APB_SAMPLE1         12'h004
`define CAO_APB_CHANNELS        12'h008
`define CAO_APB_CONTROL         12'h00c
`define CAO_APB_STATUS          12'h010

`endif

// ==== hw/cao_pkg.sv ====
// Types shared by the clocked audio output block and its stream source
package cao_pkg;
    typedef logic [23:0] cao_word_t;

    typedef enum logic [0:0] {
        CAO_SRC_IDLE = 1'b0,
        CAO_SRC_SEND = 1'b1
    } cao_src_state_e;

    typedef struct packed {
        logic      lane;
        logic      validity;
        logic      user;
        logic      status;
        cao_word_t sample;
    } cao_entry_s;
endpackage : cao_pkg

// ==== hw/cao_stream_if.sv ====
// Packet stream between audio source and clocked audio output
`timescale 1ns/100ps
interface cao_stream_if;
    logic              valid;
    logic              ready;
    logic              sop;
    logic              eop;
    logic [7:0]        channel;
    cao_pkg::cao_word_t data;

    modport source (
        output valid,
        output sop,
        output eop,
        output channel,
        output data,
        input  ready
    );

    modport sink (
        input  valid,
        input  sop,
        input  eop,
        input  channel,
        input  data,
        output ready
    );
endinterface : cao_stream_if

// ==== hw/cao_source.sv ====
// Stream source end: APB registers drive audio data and control packets
`timescale 1ns/100ps
`include "cao_defines.svh"
module cao_source (
    input  wire logic        pclk,
    input  wire logic        presetn,
    cao_stream_if.source     stream,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    cao_pkg::cao_word_t     sample0;
    cao_pkg::cao_word_t     sample1;
    logic [15:0]            channels;
    logic [5:0]             vuc;
    logic [3:0]             beat_cnt;
    cao_pkg::cao_src_state_e state;

    // ----------------------------------------------------------------
    // Beat table
    // ----------------------------------------------------------------
    function automatic logic [33:0] beat_of(input logic [3:0] idx);
        logic                lane;
        logic [3:0]          k;
        logic [7:0]          ch;
        logic [2:0]          bits;
        cao_pkg::cao_word_t  smp;
        lane = (idx >= `CAO_BEATS_PER_LANE);
        k    = lane ? idx - `CAO_BEATS_PER_LANE : idx;
        ch   = lane ? channels[15:8] : channels[7:0];
        bits = lane ? vuc[5:3] : vuc[2:0];
        smp  = lane ? sample1 : sample0;
        case (k)
            4'h0:    beat_of = {2'b10, ch, `CAO_TYPE_AUDIO_DATA};
            4'h1:    beat_of = {2'b01, ch, smp};
            4'h2:    beat_of = {2'b10, ch, `CAO_TYPE_AUDIO_CONTROL};
            4'h3:    beat_of = {2'b00, ch, 23'h00_0000, bits[0]};
            4'h4:    beat_of = {2'b00, ch, 23'h00_0000, bits[1]};
            default: beat_of = {2'b01, ch, 23'h00_0000, bits[2]};
        endcase
    endfunction : beat_of

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire        apb_setup = psel && !penable;
    wire        apb_write = psel && penable && pwrite;
    wire        go        = apb_write && (paddr == `CAO_APB_CONTROL) && pwdata[0]
                            && (state == cao_pkg::CAO_SRC_IDLE);
    wire        taken     = stream.valid && stream.ready;
    wire        last_beat = (beat_cnt == `CAO_BEATS_PER_FRAME - 4'h1);
    wire [3:0]  next_beat = go ? 4'h0 : beat_cnt + 4'h1;
    wire [33:0] next_word = beat_of(next_beat);
    wire [31:0] read_mux  =
        (paddr == `CAO_APB_SAMPLE0)  ? {8'h00, sample0} :
        (paddr == `CAO_APB_SAMPLE1)  ? {8'h00, sample1} :
        (paddr == `CAO_APB_CHANNELS) ? {16'h0000, channels} :
        (paddr == `CAO_APB_CONTROL)  ? {25'h000_0000, vuc, 1'b0} :
        (paddr == `CAO_APB_STATUS)   ? {31'h0000_0000, state == cao_pkg::CAO_SRC_SEND} :
                                       32'h0000_0000;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sample0  <= 24'h00_0000;
            sample1  <= 24'h00_0000;
            channels <= {`CAO_RST_SECOND_CHANNEL, `CAO_RST_FIRST_CHANNEL};
            vuc      <= 6'h00;
            prdata   <= 32'h0000_0000;
        end
        else
        begin
            if (apb_setup)
                prdata <= read_mux;
            if (apb_write && paddr == `CAO_APB_SAMPLE0 && state == cao_pkg::CAO_SRC_IDLE)
                sample0 <= pwdata[23:0];
            if (apb_write && paddr == `CAO_APB_SAMPLE1 && state == cao_pkg::CAO_SRC_IDLE)
                sample1 <= pwdata[23:0];
            if (apb_write && paddr == `CAO_APB_CHANNELS && state == cao_pkg::CAO_SRC_IDLE)
                channels <= pwdata[15:0];
            if (go)
                vuc <= pwdata[6:1];
        end
    end

    // ----------------------------------------------------------------
    // Stream master
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state          <= cao_pkg::CAO_SRC_IDLE;
            beat_cnt       <= 4'h0;
            stream.valid   <= 1'b0;
            stream.sop     <= 1'b0;
            stream.eop     <= 1'b0;
            stream.channel <= 8'h00;
            stream.data    <= 24'h00_0000;
        end
        else
        begin
            case (state)
                cao_pkg::CAO_SRC_IDLE:
                begin
                    if (go)
                    begin
                        state        <= cao_pkg::CAO_SRC_SEND;
                        beat_cnt     <= 4'h0;
                        stream.valid <= 1'b1;
                        {stream.sop, stream.eop, stream.channel} <= next_word[33:24];
                        stream.data  <= next_word[23:0];
                    end
                end
                cao_pkg::CAO_SRC_SEND:
                begin
                    if (taken && last_beat)
                    begin
                        state        <= cao_pkg::CAO_SRC_IDLE;
                        stream.valid <= 1'b0;
                        stream.sop   <= 1'b0;
                        stream.eop   <= 1'b0;
                    end
                    else if (taken)
                    begin
                        beat_cnt <= next_beat;
                        {stream.sop, stream.eop, stream.channel} <= next_word[33:24];
                        stream.data <= next_word[23:0];
                    end
                end
                default: state <= cao_pkg::CAO_SRC_IDLE;
            endcase
        end
    end
endmodule : cao_source

// ==== verif/cao_asserts.sv ====
// Stream link checks between the audio source and the audio output
`timescale 1ns/100ps
module cao_asserts (
    input logic               pclk,
    input logic               presetn,
    input logic               valid,
    input logic               ready,
    input logic               sop,
    input logic               eop,
    input logic [7:0]         channel,
    input cao_pkg::cao_word_t data
);
    // ------------------------------------------------------------
    // Packet checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence data_sop;
        valid && ready && sop && data == 24'h00_000a;
    endsequence
    sequence ctl_sop;
        valid && ready && sop && data == 24'h00_000e;
    endsequence
    beat_held_a: assert property (valid && !ready |=> valid && $stable(data))
        else $error("beat changed before taken");
    chan_held_a: assert property (valid && !ready |=> $stable(channel))
        else $error("channel changed before taken");
    type_id_a: assert property (valid && sop |-> data == 24'h00_000a || data == 24'h00_000e)
        else $error("bad packet type");
    sop_eop_a: assert property (valid |-> !(sop && eop))
        else $error("start and end on one beat");
    data_len_a: assert property (data_sop |-> ##[1:4] (valid && eop && !sop))
        else $error("data packet not ended");
    ctl_len_a: assert property (ctl_sop |-> ##[3:6] (valid && eop))
        else $error("control packet not ended");
    next_sop_a: assert property (valid && ready && eop |=> !valid || sop)
        else $error("packet without start");
    pkt_chan_a: assert property (valid && ready && !eop |=> !valid || channel == $past(channel))
        else $error("channel changed in packet");
endmodule : cao_asserts

// ==== verif/clocked_audio_output_tb_top.sv ====
// Bench joining audio source and audio output over the stream link
`timescale 1ns/100ps
`include "cao_defines.svh"
module clocked_audio_output_tb_top;
    logic        pclk, presetn, sclk, psel, penable, pwrite, pready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, sh;
    logic        reg_write, reg_read, fifo_status, sdata, sde, sws;
    logic [1:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [32:0] q[$];
    int          bits = 0;
    int          n_mismatch = 0;
    int          check_count = 0;
    cao_stream_if stream_link ();
    cao_source cao_source_inst (.pclk(pclk), .presetn(presetn), .stream(stream_link.source),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr());
    cao_device #(.FIFO_LOG2(3), .USE_REGS(1'b1)) cao_device_inst (.pclk(pclk),
        .presetn(presetn), .stream(stream_link.sink), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .channel0_in(8'h00), .channel1_in(8'h00),
        .fifo_reset_in(8'h00), .fifo_status(fifo_status), .serial_audio_clk(sclk),
        .serial_audio_data(sdata), .serial_audio_data_enable(sde),
        .serial_audio_word_select(sws));
    cao_asserts cao_asserts_inst (.pclk(pclk), .presetn(presetn), .valid(stream_link.valid),
        .ready(stream_link.ready), .sop(stream_link.sop), .eop(stream_link.eop),
        .channel(stream_link.channel), .data(stream_link.data));
    // ------------------------------------------------------------
    // Clocks and serial capture
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        sclk = 1'b0;
        #3;
        forever #80 sclk = ~sclk;
    end
    always @(negedge sclk)
    begin
        if (sde !== 1'b1)
            bits = 0;
        else
        begin
            sh[bits] = sdata;
            bits = bits + 1;
            if (bits == 32)
            begin
                q.push_back({sws, sh});
                bits = 0;
            end
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] sf(input logic [3:0] p, input logic [23:0] s,
                                       input logic [2:0] f);
        sf = {1'b0, f, s, p};
        sf[31] = ^sf[30:4];
    endfunction : sf
    task chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task reg_acc(input logic wr, input logic [1:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= wr;
        reg_read <= !wr;
        @(posedge pclk);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        @(posedge pclk);
    endtask : reg_acc
    task rd_chk(input logic [1:0] a, input logic [7:0] e);
        reg_acc(1'b0, a, 8'h00);
        chk({25'h0, reg_rdata}, {25'h0, e});
    endtask : rd_chk
    task send(input logic [23:0] s0, input logic [23:0] s1, input logic [5:0] f);
        apb(1'b1, 12'h000, {8'h00, s0});
        apb(1'b1, 12'h004, {8'h00, s1});
        apb(1'b1, 12'h00c, {25'h0, f, 1'b1});
        r = 32'h0000_0001;
        while (r[0] !== 1'b0) apb(1'b0, 12'h010, 32'h0000_0000);
    endtask : send
    task collect(input int n);
        repeat (4000) if (q.size() < n) @(posedge pclk);
        chk(33'(q.size() >= n), 33'h0_0000_0001);
    endtask : collect
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_regs;
        rd_chk(2'h0, 8'h01);
        rd_chk(2'h1, 8'h02);
        rd_chk(2'h3, 8'h00);
        reg_acc(1'b1, 2'h0, 8'h5a);
        reg_acc(1'b1, 2'h1, 8'ha5);
        reg_acc(1'b1, 2'h2, 8'hff);
        rd_chk(2'h0, 8'h5a);
        rd_chk(2'h1, 8'ha5);
        rd_chk(2'h2, 8'h00);
        reg_acc(1'b1, 2'h0, 8'h01);
        reg_acc(1'b1, 2'h1, 8'h02);
    endtask : t_regs
    task t_frames;
        send(24'h12_3456, 24'hab_cdef, 6'b010_101);
        send(24'h00_0001, 24'h80_0000, 6'b111_000);
        collect(4);
        chk(q.pop_front(), {1'b0, sf(4'h2, 24'h12_3456, 3'b101)});
        chk(q.pop_front(), {1'b1, sf(4'h1, 24'hab_cdef, 3'b010)});
        chk(q.pop_front(), {1'b0, sf(4'h0, 24'h00_0001, 3'b000)});
        chk(q.pop_front(), {1'b1, sf(4'h1, 24'h80_0000, 3'b111)});
    endtask : t_frames
    task t_drop;
        reg_acc(1'b1, 2'h0, 8'h05);
        send(24'h65_4321, 24'h0f_0f0f, 6'b100_001);
        collect(1);
        repeat (700) @(posedge pclk);
        chk(33'(q.size()), 33'h0_0000_0001);
        chk(q.pop_front(), {1'b1, sf(4'h1, 24'h0f_0f0f, 3'b100)});
        reg_acc(1'b1, 2'h0, 8'h01);
    endtask : t_drop
    task t_overflow;
        repeat (6) send(24'h11_1111, 24'h22_2222, 6'b000_000);
        rd_chk(2'h2, 8'h01);
        chk({32'h0, fifo_status}, 33'h0_0000_0001);
        reg_acc(1'b1, 2'h3, 8'h7f);
        rd_chk(2'h2, 8'h01);
        fork
            send(24'h33_3333, 24'h44_4444, 6'b000_000);
            begin
                @(posedge pclk iff stream_link.valid);
                reg_acc(1'b1, 2'h3, 8'h80);
            end
        join
        rd_chk(2'h2, 8'h00);
    endtask : t_overflow
    task close_out;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    initial
    begin
        #500000;
        n_mismatch++;
        close_out;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, reg_write, reg_read} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_frames;
        t_drop;
        t_overflow;
        close_out;
    end
endmodule : clocked_audio_output_tb_top
